// ### core/owfc_defines.svh
// constants for the fuse-backed wiper control block
`ifndef OWFC_DEFINES_SVH
`define OWFC_DEFINES_SVH
`define OWFC_CODE_W 6
`define OWFC_TAPS 64
`define OWFC_MIDSCALE 6'h20
`define OWFC_CODE_ZERO 6'h00
`define OWFC_ADDR_FIXED 6'h16
`define OWFC_ADDR_W 7
`define OWFC_ADDR_SEL_BIT 0
`define OWFC_RW_BIT 0
`define OWFC_COMMIT_BIT 6
`define OWFC_BITS_BYTE 4'h8
`define OWFC_BIT_LAST 4'h7
`define OWFC_VAL_READY 2'h0
`define OWFC_VAL_TESTFAIL 2'h1
`define OWFC_VAL_FATAL 2'h2
`define OWFC_VAL_DONE 2'h3
`define OWFC_BURN_NS 400000000
`define OWFC_CLK_NS 5
`define OWFC_BURN_CYC (`OWFC_BURN_NS / `OWFC_CLK_NS)
`define OWFC_BURN_CNT_W 27
`define OWFC_REG_CODE 32'h0000_0000
`define OWFC_REG_STATUS 32'h0000_0004
`define OWFC_REG_CTRL 32'h0000_0008
`define OWFC_REG_IRQ_STAT 32'h0000_000C
`define OWFC_REG_IRQ_EN 32'h0000_0010
`define OWFC_REG_IRQ_CLR 32'h0000_0014
`define OWFC_IRQ_W 4
`define OWFC_IRQ_WRITE 0
`define OWFC_IRQ_READ 1
`define OWFC_IRQ_BURN 2
`define OWFC_IRQ_REFUSE 3
`endif

// ### core/owfc_pkg.sv
// type definitions for the fuse-backed wiper control block
package owfc_pkg;
  // serial slave states, gray coded along the usual path
  typedef enum logic [2:0] {
    OWFC_IDLE = 3'h0,
    OWFC_ADDR = 3'h1,
    OWFC_AACK = 3'h3,
    OWFC_WDAT = 3'h2,
    OWFC_DACK = 3'h6,
    OWFC_RDAT = 3'h7,
    OWFC_RACK = 3'h5,
    OWFC_SKIP = 3'h4
  } owfc_state_e;
endpackage

// ### core/owfc_sync.sv
// three-stage input synchroniser with agree filter
`timescale 1ns/1ps
module owfc_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous level in, filtered level out
  input wire logic async_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // shift chain; only s2 reads s1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a change once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 1'b1;
    end else if (s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end
endmodule

// ### core/owfc_core.sv
// fuse-backed wiper code control with two-wire slave and wishbone regs
`timescale 1ns/1ps
`include "owfc_defines.svh"

module owfc_core (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // two-wire serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic address_select_pin_i,
  // fuse programming supply present
  input wire logic fuse_programming_supply_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // analog side and interrupt
  output logic [`OWFC_TAPS-1:0] tap_sel_o,
  output logic [`OWFC_CODE_W-1:0] wiper_code_o,
  output logic irq_o
);
  import owfc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic ad_s;
  logic sup_s;
  logic scl_d1_q;
  logic sda_d1_q;

  owfc_sync u_scl (.clk_i(clk_i), .rst_i(rst_i), .async_i(scl_i),
                   .level_o(scl_s));
  owfc_sync u_sda (.clk_i(clk_i), .rst_i(rst_i), .async_i(sda_i),
                   .level_o(sda_s));
  owfc_sync u_ad (.clk_i(clk_i), .rst_i(rst_i),
                  .async_i(address_select_pin_i), .level_o(ad_s));
  owfc_sync u_sup (.clk_i(clk_i), .rst_i(rst_i),
                   .async_i(fuse_programming_supply_i), .level_o(sup_s));

  // edge history of the filtered lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_s & ~scl_d1_q;
  assign scl_fall = ~scl_s & scl_d1_q;
  assign start_det = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  assign stop_det = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

  // ----------------------------------------------------------------
  // fuse array model and code latch
  // ----------------------------------------------------------------
  // fuses keep their state through rst_i; blank at start
  logic [`OWFC_CODE_W-1:0] data_fuse_q = `OWFC_CODE_ZERO;
  logic test_fuse_q = 1'b0;
  logic lock_fuse_q = 1'b0;
  logic fatal_q = 1'b0;
  logic [`OWFC_CODE_W-1:0] wiper_code_latch;
  logic burning_q;
  logic [`OWFC_BURN_CNT_W-1:0] burn_cnt_q;
  logic [`OWFC_CODE_W-1:0] burn_code_q;
  logic boot_q;
  logic [1:0] validation;
  logic validation_bit_high;
  logic validation_bit_low;
  logic ctrl_fatal_inj_q;

  // fused data sets the validation pair
  always_comb begin
    if (lock_fuse_q && test_fuse_q) begin
      validation = `OWFC_VAL_DONE;
    end else if (fatal_q) begin
      validation = `OWFC_VAL_FATAL;
    end else if (lock_fuse_q) begin
      validation = `OWFC_VAL_TESTFAIL;
    end else begin
      validation = `OWFC_VAL_READY;
    end
  end
  assign validation_bit_high = validation[1];
  assign validation_bit_low = validation[0];

  // serial write events from the slave engine
  logic wr_evt;
  logic [`OWFC_CODE_W-1:0] wr_code;
  logic wr_commit;
  logic wr_refused;
  assign wr_refused = wr_evt & (lock_fuse_q | fatal_q | burning_q);

  // fuse burn sequence; one attempt only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      burning_q <= 1'b0;
      burn_cnt_q <= '0;
      burn_code_q <= '0;
    end else if (burning_q) begin
      if (burn_cnt_q == `OWFC_BURN_CNT_W'(`OWFC_BURN_CYC - 1)) begin
        burning_q <= 1'b0;
      end
      burn_cnt_q <= burn_cnt_q + 1'b1;
    end else if (wr_evt && wr_commit && !wr_refused) begin
      burning_q <= 1'b1;
      burn_cnt_q <= '0;
      burn_code_q <= wr_code;
    end
  end

  logic burn_done;
  assign burn_done = burning_q &&
    (burn_cnt_q == `OWFC_BURN_CNT_W'(`OWFC_BURN_CYC - 1));

  // burn outcome: supply missing or injected fault leaves a fatal mark
  always_ff @(posedge clk_i) begin
    if (burn_done) begin
      if (sup_s && !ctrl_fatal_inj_q) begin
        data_fuse_q <= burn_code_q;
        test_fuse_q <= 1'b1;
        lock_fuse_q <= 1'b1;
      end else begin
        fatal_q <= 1'b1;
      end
    end
  end

  // power-on marker: first cycle after reset reloads the latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  // wiper code latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wiper_code_latch <= `OWFC_MIDSCALE;
    end else if (boot_q) begin
      if (lock_fuse_q) begin
        wiper_code_latch <= data_fuse_q;
      end else begin
        wiper_code_latch <= `OWFC_MIDSCALE;
      end
    end else if (wr_evt && !wr_refused) begin
      wiper_code_latch <= wr_code;
    end
  end

  // one-hot tap decode, bit 0 is terminal B
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tap_sel_o <= '0;
    end else begin
      tap_sel_o <= `OWFC_TAPS'(1) << wiper_code_latch;
    end
  end
  assign wiper_code_o = wiper_code_latch;

  // ----------------------------------------------------------------
  // two-wire slave engine
  // ----------------------------------------------------------------
  owfc_state_e state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic is_read_q;
  logic rd_evt;
  logic [7:0] addr_byte;
  logic [7:0] data_byte;
  assign addr_byte = {shift_q[6:0], sda_s};
  assign data_byte = {shift_q[6:0], sda_s};

  logic addr_match;
  assign addr_match = (addr_byte[7:2] == `OWFC_ADDR_FIXED) &&
                      (addr_byte[1] == ad_s);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= OWFC_IDLE;
      bit_cnt_q <= '0;
      shift_q <= '0;
      is_read_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= OWFC_IDLE;
    end else if (start_det) begin
      state_q <= OWFC_ADDR;
      bit_cnt_q <= '0;
    end else begin
      case (state_q)
        OWFC_IDLE: begin
          bit_cnt_q <= '0;
        end
        OWFC_ADDR: begin
          if (scl_rise) begin
            shift_q <= addr_byte;
            bit_cnt_q <= bit_cnt_q + 1'b1;
            if (bit_cnt_q == `OWFC_BIT_LAST) begin
              is_read_q <= addr_byte[`OWFC_RW_BIT];
              state_q <= addr_match ? OWFC_AACK : OWFC_SKIP;
            end
          end
        end
        OWFC_AACK: begin
          if (scl_fall && bit_cnt_q == `OWFC_BITS_BYTE) begin
            bit_cnt_q <= '0;
          end else if (scl_fall) begin
            state_q <= is_read_q ? OWFC_RDAT : OWFC_WDAT;
            bit_cnt_q <= '0;
            shift_q <= {validation, wiper_code_latch};
          end
        end
        OWFC_WDAT: begin
          if (scl_rise) begin
            shift_q <= data_byte;
            bit_cnt_q <= bit_cnt_q + 1'b1;
            if (bit_cnt_q == `OWFC_BIT_LAST) begin
              state_q <= OWFC_DACK;
            end
          end
        end
        OWFC_DACK: begin
          if (scl_fall && bit_cnt_q == `OWFC_BITS_BYTE) begin
            bit_cnt_q <= '0;
          end else if (scl_fall) begin
            state_q <= OWFC_SKIP;
          end
        end
        OWFC_RDAT: begin
          if (scl_fall) begin
            shift_q <= {shift_q[6:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 1'b1;
            if (bit_cnt_q == `OWFC_BIT_LAST) begin
              state_q <= OWFC_RACK;
            end
          end
        end
        OWFC_RACK: begin
          if (scl_rise) begin
            state_q <= OWFC_SKIP;
          end
        end
        OWFC_SKIP: begin
          bit_cnt_q <= '0;
        end
        default: begin
          state_q <= OWFC_IDLE;
        end
      endcase
    end
  end

  // data byte capture into a write event
  assign wr_evt = (state_q == OWFC_WDAT) && scl_rise &&
                  (bit_cnt_q == `OWFC_BIT_LAST) && !stop_det && !start_det;
  assign wr_code = data_byte[`OWFC_CODE_W-1:0];
  assign wr_commit = data_byte[`OWFC_COMMIT_BIT];
  assign rd_evt = (state_q == OWFC_RACK) && scl_rise;

  // open-drain drive: low during acks and zero read bits
  // ack waits for the eighth clock to fall, never moving sda under scl high
  always_comb begin
    sda_o = 1'b0;
    case (state_q)
      OWFC_AACK: sda_oe_o = (bit_cnt_q != `OWFC_BITS_BYTE);
      OWFC_DACK: sda_oe_o = (bit_cnt_q != `OWFC_BITS_BYTE);
      OWFC_RDAT: sda_oe_o = ~shift_q[7];
      default: sda_oe_o = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // wishbone registers and interrupts
  // ----------------------------------------------------------------
  logic [`OWFC_IRQ_W-1:0] irq_stat_q;
  logic [`OWFC_IRQ_W-1:0] irq_en_q;
  logic [`OWFC_IRQ_W-1:0] irq_evt;
  logic wb_req;
  logic wb_hit;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wb_hit = (wb_adr_i == `OWFC_REG_CODE) ||
                  (wb_adr_i == `OWFC_REG_STATUS) ||
                  (wb_adr_i == `OWFC_REG_CTRL) ||
                  (wb_adr_i == `OWFC_REG_IRQ_STAT) ||
                  (wb_adr_i == `OWFC_REG_IRQ_EN) ||
                  (wb_adr_i == `OWFC_REG_IRQ_CLR);

  assign irq_evt[`OWFC_IRQ_WRITE] = wr_evt & ~wr_refused;
  assign irq_evt[`OWFC_IRQ_READ] = rd_evt;
  assign irq_evt[`OWFC_IRQ_BURN] = burn_done;
  assign irq_evt[`OWFC_IRQ_REFUSE] = wr_refused;

  logic clr_wr;
  assign clr_wr = wb_req & wb_we_i & wb_sel_i[0] &
                  (wb_adr_i == `OWFC_REG_IRQ_CLR);

  // sticky status; a new event wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q &
                     ~(clr_wr ? wb_dat_i[`OWFC_IRQ_W-1:0] : '0)) | irq_evt;
    end
  end

  // writable control: irq enables and test fault injection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_q <= '0;
      ctrl_fatal_inj_q <= 1'b0;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == `OWFC_REG_IRQ_EN) begin
        irq_en_q <= wb_dat_i[`OWFC_IRQ_W-1:0];
      end
      if (wb_adr_i == `OWFC_REG_CTRL) begin
        ctrl_fatal_inj_q <= wb_dat_i[0];
      end
    end
  end

  // one-wait answer with read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req & wb_hit;
      wb_err_o <= wb_req & ~wb_hit;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `OWFC_REG_CODE: wb_dat_o <= 32'(wiper_code_latch);
          `OWFC_REG_STATUS: wb_dat_o <= 32'({burning_q, fatal_q,
            lock_fuse_q, test_fuse_q, validation_bit_high,
            validation_bit_low});
          `OWFC_REG_CTRL: wb_dat_o <= 32'(ctrl_fatal_inj_q);
          `OWFC_REG_IRQ_STAT: wb_dat_o <= 32'(irq_stat_q);
          `OWFC_REG_IRQ_EN: wb_dat_o <= 32'(irq_en_q);
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // level interrupt
  assign irq_o = |(irq_stat_q & irq_en_q);
endmodule

// ### test/owfc_properties.sv
// port checker for the fuse-backed wiper control block
`timescale 1ns/1ps
module owfc_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched pins
  input wire logic sda_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [63:0] tap_sel_o,
  input wire logic [5:0] wiper_code_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answer one cycle after the request
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no bus answer");
  property p_ack_pulse;
    wb_ack_o || wb_err_o |=> !(wb_ack_o || wb_err_o);
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("answer too long");
  property p_excl;
    !(wb_ack_o && wb_err_o);
  endproperty
  a_excl: assert property (p_excl) else $error("ack and err together");
  property p_ack_map;
    wb_ack_o |-> $past(wb_adr_i[31:2]) <= 30'h5;
  endproperty
  a_ack_map: assert property (p_ack_map) else $error("ack on unmapped");
  property p_err_map;
    wb_err_o |-> $past(wb_adr_i[31:2]) > 30'h5 || $past(wb_adr_i[1:0]) != 2'h0;
  endproperty
  a_err_map: assert property (p_err_map) else $error("err on mapped");
  property p_code_read;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 32'h0
      |-> wb_dat_o[5:0] == $past(wiper_code_o);
  endproperty
  a_code_read: assert property (p_code_read) else $error("bad code read");
  property p_tap;
    !$past(rst_i) && !$past(rst_i, 2) && $stable(wiper_code_o)
      |-> tap_sel_o == (64'h1 << wiper_code_o);
  endproperty
  a_tap: assert property (p_tap) else $error("tap does not match code");
  property p_onehot;
    !$past(rst_i) |-> $onehot(tap_sel_o);
  endproperty
  a_onehot: assert property (p_onehot) else $error("tap not one-hot");
  property p_open_drain;
    sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");
endmodule
bind owfc_core owfc_properties owfc_properties_i (
  .clk_i(clk_i), .rst_i(rst_i), .sda_o(sda_o), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .tap_sel_o(tap_sel_o), .wiper_code_o(wiper_code_o));

// ### test/owfc_i2c_master.sv
// two-wire bus master model driving the wiper control block
`timescale 1ns/1ps
module owfc_i2c_master (
  // clock and bus level
  input wire logic clk_i,
  input wire logic sda_i,
  // driven pins, sda as a pull-low flag
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // half of a serial clock period
  task automatic hp;
    repeat (12) @(posedge clk_i);
  endtask
  // one bit out, bus level back while scl high
  task automatic bit_x(input logic b, output logic r);
    sda_low_o <= ~b;
    hp();
    scl_o <= 1'b1;
    hp();
    r = sda_i;
    scl_o <= 1'b0;
    repeat (4) @(posedge clk_i); // hold sda past the scl fall
  endtask
  // start, address byte, one data byte, stop
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic [1:0] ak);
    logic r;
    @(posedge clk_i);
    sda_low_o <= 1'b1;
    hp();
    scl_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 7; i >= 0; i--) bit_x(a[i], r);
    bit_x(1'b1, r);
    ak[1] = ~r;
    // a read releases the line so the device drives it
    for (int i = 7; i >= 0; i--) bit_x(a[0] | d[i], q[i]);
    bit_x(1'b1, r); // nack on read, released for ack on write
    ak[0] = ~r;
    sda_low_o <= 1'b1;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_low_o <= 1'b0;
    hp();
  endtask
endmodule

// ### test/tb_otp_wiper_fuse_ctrl.sv
// self-checking bench for the fuse-backed wiper control block
`timescale 1ns/1ps
module tb_otp_wiper_fuse_ctrl;
  logic clk_i = 0, rst_i = 1, pin = 0, supply = 0;
  logic cyc = 0, stb = 0, we = 0;
  logic [31:0] adr = 0, wdat = 0, q32;
  logic [3:0] sel = 0;
  logic [7:0] q;
  logic [1:0] ak;
  logic e, sda_o, oe, ack, err, irq, scl, low;
  logic [31:0] rdat;
  logic [63:0] tap;
  logic [5:0] code;
  int n_errors = 0, samples_checked = 0;
  wire sda_bus = ~(low | oe); // pulled up unless someone pulls low
  always #2.5 clk_i = ~clk_i;
  owfc_core owfc_core_i (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
    .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_o(oe), .address_select_pin_i(pin),
    .fuse_programming_supply_i(supply), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .tap_sel_o(tap),
    .wiper_code_o(code), .irq_o(irq));
  owfc_i2c_master owfc_i2c_master_i (.clk_i(clk_i), .sda_i(sda_bus),
    .scl_o(scl), .sda_low_o(low));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    // answer sampled at a rising edge; ack or err ends the wait, and only the watchdog ends a hung one
    do begin
      @(posedge clk_i);
    end while (!(ack || err));
    q32 = rdat;
    e = err;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic i2c(input logic rd, input logic [7:0] d);
    owfc_i2c_master_i.xfer({6'h16, pin, rd}, d, q, ak);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    @(posedge clk_i);
    rst_i <= 1;
    repeat (2) @(negedge clk_i);
    chk(tap, 64'h0);
    @(posedge clk_i);
    rst_i <= 0;
    repeat (3) @(negedge clk_i);
    chk(code, 6'h20);
    chk(tap, 64'h1 << 32);
  endtask
  task automatic t_write;
    logic [5:0] c [3] = '{6'h00, 6'h01, 6'h3F};
    foreach (c[i]) begin
      i2c(1'b0, {2'h0, c[i]});
      chk(ak, 2'h3);
      chk(code, c[i]);
      chk(tap, 64'h1 << c[i]);
    end
    i2c(1'b1, 8'hFF);
    chk(ak[1], 1'b1);
    chk(q, 8'h3F);
  endtask
  task automatic t_addr;
    @(posedge clk_i);
    pin <= 1;
    repeat (8) @(posedge clk_i);
    owfc_i2c_master_i.xfer(8'h58, 8'h11, q, ak);
    chk(ak[1], 1'b0);
    chk(code, 6'h3F);
    i2c(1'b0, 8'h15);
    chk(ak, 2'h3);
    chk(code, 6'h15);
  endtask
  task automatic t_regs;
    wb(1'b1, 32'h14, 32'hF);
    wb(1'b1, 32'h10, 32'h1);
    chk(irq, 1'b0);
    i2c(1'b0, 8'h07);
    chk(irq, 1'b1);
    wb(1'b0, 32'h0C, 0);
    chk(q32[0], 1'b1);
    wb(1'b1, 32'h14, 32'h1);
    @(negedge clk_i);
    chk(irq, 1'b0);
    wb(1'b1, 32'h10, 32'h0);
    i2c(1'b0, 8'h08);
    chk(irq, 1'b0);
    wb(1'b0, 32'h0, 0);
    chk(q32[5:0], 6'h08);
    wb(1'b0, 32'h4, 0);
    chk(q32[1:0], 2'h0);
    wb(1'b0, 32'h18, 0);
    chk(e, 1'b1);
    wb(1'b1, 32'h8, 32'h1);
    wb(1'b0, 32'h8, 0);
    chk(q32[0], 1'b1);
  endtask
  task automatic t_commit;
    i2c(1'b0, 8'h2A);
    @(posedge clk_i);
    supply <= 1;
    i2c(1'b0, 8'h6A);
    chk(ak, 2'h3);
    chk(code, 6'h2A);
    wb(1'b0, 32'h4, 0);
    chk(q32[5], 1'b1);
    chk(q32[3:0], 4'h0);
    i2c(1'b1, 8'hFF);
    chk(q, 8'h2A);
    i2c(1'b0, 8'h05);
    chk(ak, 2'h3);
    chk(code, 6'h2A);
    wb(1'b0, 32'h0C, 0);
    chk(q32[3], 1'b1);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    t_reset();
    t_write();
    t_addr();
    t_regs();
    t_reset();
    t_commit();
    summarize();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    summarize();
  end
endmodule
